// *** rtl/atrb_bank.sv ***
// Telemetry result bank with its serial management bus slave.
// Assumes results arrive from the converter core on clk_sys_i with a one-cycle valid.
`timescale 1ns/100ps
module atrb_bank (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_drive_n_o,
  input  wire logic [3:0]                  addr_strap_i,
  input  wire logic                        result_valid_i,
  input  wire logic [atrb_pkg::RES_W-1:0]  port3_pin_level_i,
  input  wire logic [atrb_pkg::RES_W-1:0]  port4_current_i,
  input  wire logic [atrb_pkg::RES_W-1:0]  port4_pin_level_i,
  input  wire logic [atrb_pkg::RES_W-1:0]  supply_level_i,
  input  wire logic [atrb_pkg::RES_W-1:0]  die_temp_i,
  input  wire logic [atrb_pkg::RES_W-1:0]  power_budget_pin_i,
  output logic [atrb_pkg::RES_W-1:0]       power_budget_value_o,
  output logic                             budget_captured_o
);
  import atrb_pkg::*;

  // Pin synchronisers: bit 5 is clock, bit 4 data, bits 3:0 address straps.
  logic [5:0] pins_s;
  atrb_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_sys_i     (clk_sys_i),
    .rst_i         (rst_i),
    .async_i       ({scl_i, sda_i, addr_strap_i}),
    .reset_level_i (6'h3F),
    .sync_o        (pins_s)
  );

  logic scl_s;
  logic sda_s;
  logic [3:0] strap_s;
  assign scl_s   = pins_s[5];
  assign sda_s   = pins_s[4];
  assign strap_s = pins_s[3:0];

  // Results as delivered by the converter; no scaling is applied here.
  logic [RES_W-1:0] port3_q;
  logic [RES_W-1:0] port3_d;
  logic [RES_W-1:0] curr4_q;
  logic [RES_W-1:0] curr4_d;
  logic [RES_W-1:0] port4_q;
  logic [RES_W-1:0] port4_d;
  logic [RES_W-1:0] supply_q;
  logic [RES_W-1:0] supply_d;
  logic [RES_W-1:0] temp_q;
  logic [RES_W-1:0] temp_d;
  logic [RES_W-1:0] budget_q;
  logic [RES_W-1:0] budget_d;
  logic             captured_q;
  logic             captured_d;

  // Bus slave state.
  atrb_state_type   st_q;
  atrb_state_type   st_d;
  logic             scl_p_q;
  logic             sda_p_q;
  logic [3:0]       cnt_q;
  logic [3:0]       cnt_d;
  logic [7:0]       sh_q;
  logic [7:0]       sh_d;
  logic [7:0]       tx_q;
  logic [7:0]       tx_d;
  logic [7:0]       ptr_q;
  logic [7:0]       ptr_d;
  logic             drv_q;
  logic             drv_d;
  logic             more_q;
  logic             more_d;
  logic             wr_en;
  logic [7:0]       rd_data;

  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  // Low byte carries only bit 0 of the count; high byte carries bits 8:1.
  function automatic logic [7:0] split_byte(input logic [RES_W-1:0] v, input logic hi);
    if (hi) begin
      split_byte = v[RES_W-1:1];
    end else begin
      split_byte = {7'h00, v[0]};
    end
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] ofs);
    case (ofs)
      OFS_PORT3_PIN_VOLT_LOW:  read_reg = split_byte(port3_q, 1'b0);
      OFS_PORT3_PIN_VOLT_HIGH: read_reg = split_byte(port3_q, 1'b1);
      OFS_PORT4_CURRENT_LOW:   read_reg = split_byte(curr4_q, 1'b0);
      OFS_PORT4_CURRENT_HIGH:  read_reg = split_byte(curr4_q, 1'b1);
      OFS_PORT4_PIN_VOLT_LOW:  read_reg = split_byte(port4_q, 1'b0);
      OFS_PORT4_PIN_VOLT_HIGH: read_reg = split_byte(port4_q, 1'b1);
      OFS_SUPPLY_VOLT_LOW:     read_reg = split_byte(supply_q, 1'b0);
      OFS_SUPPLY_VOLT_HIGH:    read_reg = split_byte(supply_q, 1'b1);
      OFS_DIE_TEMP_LOW:        read_reg = split_byte(temp_q, 1'b0);
      OFS_DIE_TEMP_HIGH:       read_reg = split_byte(temp_q, 1'b1);
      OFS_POWER_BUDGET_LOW:    read_reg = split_byte(budget_q, 1'b0);
      OFS_POWER_BUDGET_HIGH:   read_reg = split_byte(budget_q, 1'b1);
      OFS_CHIP_IDENTITY: begin
        read_reg = 8'h00;
        read_reg[ID_SITE_POS +: 2]  = ID_SITE;
        read_reg[ID_BIG_POS +: 2]   = ID_BIG_REVISION;
        read_reg[ID_SMALL_POS +: 2] = ID_SMALL_REVISION;
        read_reg[ID_SUPP_POS +: 2]  = ID_SUPPLIER_CODE;
      end
      default: read_reg = UNMAPPED_READ;
    endcase
  endfunction

  always_comb rd_data = read_reg(ptr_q);

  // Result capture. Pin levels are kept as raw counts so software can form the
  // delivered voltage from supply and pin counts itself.
  // Current, temperature and power keep their raw counts too.
  always_comb begin
    port3_d    = port3_q;
    curr4_d    = curr4_q;
    port4_d    = port4_q;
    supply_d   = supply_q;
    temp_d     = temp_q;
    budget_d   = budget_q;
    captured_d = captured_q;
    if (result_valid_i) begin
      port3_d  = port3_pin_level_i;
      curr4_d  = port4_current_i;
      port4_d  = port4_pin_level_i;
      supply_d = supply_level_i;
      temp_d   = die_temp_i;
      // The budget is sampled only by the first conversion after reset.
      if (!captured_q) begin
        budget_d   = power_budget_pin_i;
        captured_d = 1'b1;
      end
    end
    // A host write replaces the budget; it takes priority over capture in the same cycle.
    if (wr_en && ptr_q == OFS_POWER_BUDGET_LOW) begin
      budget_d[0] = sh_q[0];
    end
    if (wr_en && ptr_q == OFS_POWER_BUDGET_HIGH) begin
      budget_d[RES_W-1:1] = sh_q;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port3_q    <= RES_RESET;
      curr4_q    <= RES_RESET;
      port4_q    <= RES_RESET;
      supply_q   <= RES_RESET;
      temp_q     <= RES_RESET;
      budget_q   <= RES_RESET;
      captured_q <= 1'b0;
    end else begin
      port3_q    <= port3_d;
      curr4_q    <= curr4_d;
      port4_q    <= port4_d;
      supply_q   <= supply_d;
      temp_q     <= temp_d;
      budget_q   <= budget_d;
      captured_q <= captured_d;
    end
  end

  // Bus slave. Data is sampled on the rising clock and changed on the falling one.
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    tx_d   = tx_q;
    ptr_d  = ptr_q;
    drv_d  = drv_q;
    more_d = more_q;
    wr_en  = 1'b0;
    if (stop_ev) begin
      st_d  = ATRB_IDLE;
      drv_d = 1'b0;
    end else if (start_ev) begin
      st_d  = ATRB_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        ATRB_IDLE: begin
          drv_d = 1'b0;
        end
        ATRB_ADDR, ATRB_REG, ATRB_WR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            drv_d = 1'b1;
            case (st_q)
              ATRB_ADDR: begin
                if (sh_q[7:1] == {BUS_ADDR_UPPER, strap_s}) begin
                  st_d   = ATRB_ACK_A;
                  more_d = sh_q[0];
                end else begin
                  st_d  = ATRB_IDLE;
                  drv_d = 1'b0;
                end
              end
              ATRB_REG: begin
                ptr_d = sh_q;
                st_d  = ATRB_ACK_R;
              end
              default: begin
                wr_en = 1'b1;
                ptr_d = ptr_q + 8'h01;
                st_d  = ATRB_ACK_W;
              end
            endcase
          end
        end
        ATRB_ACK_A, ATRB_ACK_R, ATRB_ACK_W: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            drv_d = 1'b0;
            if (st_q == ATRB_ACK_A && more_q) begin
              // Auto-increment lets a host walk low then high byte in one transfer.
              tx_d  = rd_data;
              ptr_d = ptr_q + 8'h01;
              drv_d = ~rd_data[7];
              st_d  = ATRB_RD;
            end else if (st_q == ATRB_ACK_A) begin
              st_d = ATRB_REG;
            end else begin
              st_d = ATRB_WR;
            end
          end
        end
        ATRB_RD: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == BITS_PER_BYTE) begin
              drv_d = 1'b0;
              st_d  = ATRB_RACK;
            end else begin
              tx_d  = {tx_q[6:0], 1'b0};
              drv_d = ~tx_q[6];
            end
          end
        end
        ATRB_RACK: begin
          if (scl_rise) begin
            more_d = ~sda_s;
          end else if (scl_fall) begin
            if (more_q) begin
              tx_d  = rd_data;
              ptr_d = ptr_q + 8'h01;
              drv_d = ~rd_data[7];
              cnt_d = 4'h0;
              st_d  = ATRB_RD;
            end else begin
              st_d = ATRB_IDLE;
            end
          end
        end
        default: begin
          st_d  = ATRB_IDLE;
          drv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q    <= ATRB_IDLE;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      drv_q   <= 1'b0;
      more_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      tx_q    <= tx_d;
      ptr_q   <= ptr_d;
      drv_q   <= drv_d;
      more_q  <= more_d;
    end
  end

  // Open-drain data: the level is always low, the active-low enable gates it.
  logic sda_drive_n_q;
  logic sda_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sda_drive_n_q <= 1'b1;
      sda_q         <= 1'b0;
    end else begin
      sda_drive_n_q <= ~drv_d;
      sda_q         <= 1'b0;
    end
  end

  assign sda_o                = sda_q;
  assign sda_drive_n_o        = sda_drive_n_q;
  assign power_budget_value_o = budget_q;
  assign budget_captured_o    = captured_q;
endmodule

// *** rtl/atrb_pkg.sv ***
// Constants for the telemetry result bank: register offsets, result layout, bus address.
// Assumes the serial management bus runs slowly enough for the system clock to sample it.
// How it works
// - Port 3 pin voltage bit 0 sits in 4Ah, upper bits in 4Bh.
// - The port 3 pair holds the pin voltage, not the delivered voltage.
// - Delivered voltage is 0.15 V times supply count minus pin count.
// - Port 4 current bit 0 sits in 4Ch, upper bits in 4Dh.
// - Port current is 2.4 mA per count minus 10 mA.
// - Port 4 pin voltage bit 0 sits in 4Eh, upper bits in 4Fh.
// - Supply voltage sits in 50h and 51h, 0.15 V per count.
// - Die temperature bit 0 sits in 52h, upper bits in 53h.
// - Die temperature is 0.4 C per count minus 40 C.
// - Power budget bit 0 sits in 54h, upper bits in 55h.
// - Power budget count means 0.4 W of allowed load per count.
// - Power budget is captured once after reset and then held until a host writes 54h or 55h.
// - Identity byte: site 7:6, big revision 5:4, small 3:2, supplier 1:0.
package atrb_pkg;

  localparam int unsigned RES_W = 9;
  localparam int unsigned SYNC_STAGES = 2;

  // Register offsets on the management bus.
  localparam logic [7:0] OFS_PORT3_PIN_VOLT_LOW  = 8'h4A;
  localparam logic [7:0] OFS_PORT3_PIN_VOLT_HIGH = 8'h4B;
  localparam logic [7:0] OFS_PORT4_CURRENT_LOW   = 8'h4C;
  localparam logic [7:0] OFS_PORT4_CURRENT_HIGH  = 8'h4D;
  localparam logic [7:0] OFS_PORT4_PIN_VOLT_LOW  = 8'h4E;
  localparam logic [7:0] OFS_PORT4_PIN_VOLT_HIGH = 8'h4F;
  localparam logic [7:0] OFS_SUPPLY_VOLT_LOW     = 8'h50;
  localparam logic [7:0] OFS_SUPPLY_VOLT_HIGH    = 8'h51;
  localparam logic [7:0] OFS_DIE_TEMP_LOW        = 8'h52;
  localparam logic [7:0] OFS_DIE_TEMP_HIGH       = 8'h53;
  localparam logic [7:0] OFS_POWER_BUDGET_LOW    = 8'h54;
  localparam logic [7:0] OFS_POWER_BUDGET_HIGH   = 8'h55;
  localparam logic [7:0] OFS_CHIP_IDENTITY       = 8'h60;

  localparam logic [RES_W-1:0] RES_RESET = 9'h000;
  localparam logic [7:0]       UNMAPPED_READ = 8'h00;

  // Identity fields; these values are arbitrary.
  localparam logic [1:0] ID_SITE           = 2'h1;
  localparam logic [1:0] ID_BIG_REVISION   = 2'h2;
  localparam logic [1:0] ID_SMALL_REVISION = 2'h3;
  localparam logic [1:0] ID_SUPPLIER_CODE  = 2'h1;
  localparam int unsigned ID_SITE_POS  = 6;
  localparam int unsigned ID_BIG_POS   = 4;
  localparam int unsigned ID_SMALL_POS = 2;
  localparam int unsigned ID_SUPP_POS  = 0;

  // Bus address is a fixed upper part above four strap pins.
  localparam logic [2:0] BUS_ADDR_UPPER = 3'h2;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // Scale factors of the counts, for software; the bank itself never rescales.
  localparam int unsigned VOLT_UV_PER_COUNT    = 150000;
  localparam int unsigned CURR_UA_PER_COUNT    = 2400;
  localparam int unsigned CURR_OFFSET_UA       = 10000;
  localparam int unsigned TEMP_MC_PER_COUNT    = 400;
  localparam int unsigned TEMP_OFFSET_MC       = 40000;
  localparam int unsigned POWER_MW_PER_COUNT   = 400;

  typedef enum logic [8:0] {
    ATRB_IDLE  = 9'h001,
    ATRB_ADDR  = 9'h002,
    ATRB_ACK_A = 9'h004,
    ATRB_REG   = 9'h008,
    ATRB_ACK_R = 9'h010,
    ATRB_WR    = 9'h020,
    ATRB_ACK_W = 9'h040,
    ATRB_RD    = 9'h080,
    ATRB_RACK  = 9'h100
  } atrb_state_type;

endpackage

// *** rtl/atrb_sync.sv ***
// Two-flop synchroniser for a group of slow asynchronous pins.
// Assumes each bit changes slowly; bits of the group are not kept coherent.
`timescale 1ns/100ps
module atrb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] reset_level_i,
  output logic      [WIDTH-1:0] sync_o
);
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic stab_q;
      logic stab_d;
      always_comb begin
        meta_d = async_i[gi];
        stab_d = meta_q;
      end
      // Both stages reset to one so an idle open-drain line is not seen as a start.
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          meta_q <= 1'b1;
          stab_q <= 1'b1;
        end else begin
          meta_q <= meta_d;
          stab_q <= stab_d;
        end
      end
      assign sync_o[gi] = stab_q;
    end
  endgenerate

  logic unused_level;
  assign unused_level = ^reset_level_i;
endmodule

// *** verif/atrb_bank_assertions.sv ***
// Concurrent checks on the pins of the telemetry result bank.
// Assumes one clock domain and a host that keeps bus phases long.
`timescale 1ns/100ps
module atrb_bank_chk (
  input wire logic                       clk_sys_i,
  input wire logic                       rst_i,
  input wire logic                       scl_i,
  input wire logic                       sda_o,
  input wire logic                       sda_drive_n_o,
  input wire logic                       result_valid_i,
  input wire logic [atrb_pkg::RES_W-1:0] power_budget_pin_i,
  input wire logic [atrb_pkg::RES_W-1:0] power_budget_value_o,
  input wire logic                       budget_captured_o
);
  import atrb_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_drive_level;
    sda_o == 1'b0;
  endproperty
  a_drive_level: assert property (p_drive_level) else $error("data drive level not low");

  property p_reset_state;
    $fell(rst_i) |-> sda_drive_n_o && !budget_captured_o && power_budget_value_o == '0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_capture;
    result_valid_i && !budget_captured_o |=>
      budget_captured_o && power_budget_value_o == $past(power_budget_pin_i);
  endproperty
  a_capture: assert property (p_capture) else $error("budget not captured");

  property p_sticky;
    budget_captured_o |=> budget_captured_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("capture flag dropped");

  property p_no_early;
    !result_valid_i && !budget_captured_o |=> !budget_captured_o;
  endproperty
  a_no_early: assert property (p_no_early) else $error("capture without result");

  // The bench never writes the budget in the cycle of a result load.
  property p_ignore_later;
    budget_captured_o && result_valid_i |=> $stable(power_budget_value_o);
  endproperty
  a_ignore_later: assert property (p_ignore_later) else $error("budget recaptured");

  // A change of drive while the bus clock is high would look like a start or stop.
  property p_drive_scl_low;
    $changed(sda_drive_n_o) |-> !scl_i;
  endproperty
  a_drive_scl_low: assert property (p_drive_scl_low) else $error("drive moved, clock high");

  property p_drive_hold;
    scl_i [*4] |-> $stable(sda_drive_n_o);
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("drive unstable, clock high");
endmodule

bind atrb_bank atrb_bank_chk u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_drive_n_o(sda_drive_n_o), .result_valid_i(result_valid_i),
  .power_budget_pin_i(power_budget_pin_i), .power_budget_value_o(power_budget_value_o),
  .budget_captured_o(budget_captured_o)
);

// *** verif/atrb_host.sv ***
// Bus host model that drives the clock and data pins of the bank.
// Assumes a pull-up on the data line; a high level here means released.
`timescale 1ns/100ps
module atrb_host (
  input  wire logic clk_sys_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic put_bit(input logic b);
    sda_o <= b;
    hold(5);
    scl_o <= 1'b1;
    hold(10);
    scl_o <= 1'b0;
    hold(5);
  endtask

  task automatic get_bit(output logic b);
    sda_o <= 1'b1;
    hold(5);
    scl_o <= 1'b1;
    hold(5);
    b = sda_line_i;
    hold(5);
    scl_o <= 1'b0;
    hold(5);
  endtask

  task automatic start();
    sda_o <= 1'b1;
    hold(10);
    scl_o <= 1'b1;
    hold(10);
    sda_o <= 1'b0;
    hold(10);
    scl_o <= 1'b0;
    hold(5);
  endtask

  task automatic stop();
    sda_o <= 1'b0;
    hold(5);
    scl_o <= 1'b1;
    hold(10);
    sda_o <= 1'b1;
    hold(10);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask

  task automatic rbyte(output logic [7:0] d, input logic last);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(last);
  endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the telemetry result bank.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/100ps
module tb;
  import atrb_pkg::*;
  logic             clk_sys_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             result_valid = 1'b0;
  logic [3:0]       strap = 4'h0;
  logic [RES_W-1:0] res [6] = '{default: '0};
  logic [RES_W-1:0] exp_res [6] = '{default: '0};
  logic [7:0]       rd [16];
  logic [7:0]       lfsr_q = 8'h52;
  logic             cap_exp = 1'b0;
  logic             scl, host_sda, sda_line, sda_drv, sda_drive_n, captured, ack;
  logic [RES_W-1:0] budget;
  int               fail_count = 0;
  int               tests_run = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  assign sda_line = host_sda & (sda_drive_n | sda_drv);

  atrb_host host (.clk_sys_i(clk_sys_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(host_sda));

  atrb_bank DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv),
    .sda_drive_n_o(sda_drive_n), .addr_strap_i(strap), .result_valid_i(result_valid),
    .port3_pin_level_i(res[0]), .port4_current_i(res[1]), .port4_pin_level_i(res[2]),
    .supply_level_i(res[3]), .die_temp_i(res[4]), .power_budget_pin_i(res[5]),
    .power_budget_value_o(budget), .budget_captured_o(captured)
  );

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [8:0] next_rand();
    repeat (2) lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    return {lfsr_q[3], lfsr_q};
  endfunction

  // Slot 5 of the expected table is the held budget, which shares the pairing.
  function automatic logic [7:0] exp_byte(input logic [7:0] ofs);
    logic [8:0] c;
    if (ofs >= 8'h4A && ofs <= 8'h55) begin
      c = exp_res[(ofs - 8'h4A) >> 1];
      return ofs[0] ? c[8:1] : {7'h00, c[0]};
    end
    if (ofs == OFS_CHIP_IDENTITY)
      return {ID_SITE, ID_BIG_REVISION, ID_SMALL_REVISION, ID_SUPPLIER_CODE};
    return 8'h00;
  endfunction

  task automatic addr_phase(input logic rd_bit);
    host.start();
    host.wbyte({BUS_ADDR_UPPER, strap, rd_bit}, ack);
    check("address ack", 9'(ack), 9'h001);
  endtask

  // Low and high halves go out in one burst so they come from one conversion.
  task automatic read_burst(input logic [7:0] ptr, input int n);
    addr_phase(1'b0);
    host.wbyte(ptr, ack);
    addr_phase(1'b1);
    for (int i = 0; i < n; i++) host.rbyte(rd[i], i == n - 1);
    host.stop();
    for (int i = 0; i < n; i++)
      check("register", 9'(rd[i]), 9'(exp_byte(ptr + 8'(i))));
  endtask

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data);
    addr_phase(1'b0);
    host.wbyte(ptr, ack);
    host.wbyte(data, ack);
    host.stop();
  endtask

  task automatic load(input logic corner);
    logic [8:0] v;
    @(posedge clk_sys_i);
    for (int i = 0; i < 6; i++) begin
      v = next_rand();
      if (corner) v = i[0] ? 9'h100 : 9'h1FF;
      res[i] <= v;
      if (i < 5 || !cap_exp) exp_res[i] = v;
    end
    cap_exp = 1'b1;
    result_valid <= 1'b1;
    @(posedge clk_sys_i);
    result_valid <= 1'b0;
    host.hold(3);
    check("captured", 9'(captured), 9'h001);
    check("budget", budget, exp_res[5]);
  endtask

  initial begin
    logic [8:0] v;
    @(posedge clk_sys_i);
    v = next_rand();
    strap <= v[3:0];
    repeat (7) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    host.hold(5);
    check("captured", 9'(captured), 9'h000);
    read_burst(8'h4A, 12);
    load(1'b1);
    read_burst(8'h4A, 12);
    read_burst(8'h60, 2);
    repeat (3) begin
      load(1'b0);
      read_burst(8'h4A, 12);
    end
    write_reg(8'h54, 8'h01);
    write_reg(8'h55, 8'hA5);
    write_reg(8'h4A, 8'hFF);
    exp_res[5] = 9'h14B;
    check("budget write", budget, exp_res[5]);
    read_burst(8'h4A, 12);
    host.start();
    host.wbyte({BUS_ADDR_UPPER, ~strap, 1'b0}, ack);
    check("foreign address", 9'(ack), 9'h000);
    host.stop();
    rst_i <= 1'b1;
    host.hold(3);
    rst_i <= 1'b0;
    exp_res = '{default: '0};
    cap_exp = 1'b0;
    host.hold(5);
    check("captured", 9'(captured), 9'h000);
    read_burst(8'h4A, 12);
    load(1'b0);
    read_burst(8'h4A, 12);
    give_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    fail_count++;
    give_verdict();
  end
endmodule
